// ===== core/adcm_pkg.sv
// Shared constants, types and reset values for the digital comparator block
package adcm_pkg;

    localparam int RES_W     = 12;     // Conversion result width
    localparam int CMP_IDX_W = 3;      // Comparator index width, up to eight units
    localparam int SEQ_W     = 2;      // Sample sequence number width
    localparam int NUM_SEQ   = 4;      // Sample sequences in the converter
    localparam int ADDR_W    = 12;     // APB address bits decoded
    localparam int DATA_W    = 32;     // APB data width
    localparam int MODE_W    = 4;      // Width of one mode selection

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_BUSY     = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_SEQ_EN   = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_MASK     = 12'h00C;
    localparam logic [ADDR_W-1:0] ADDR_CLR_HIST = 12'h010;
    localparam logic [ADDR_W-1:0] ADDR_CFG_BASE = 12'h040;
    localparam logic [ADDR_W-1:0] ADDR_THR_BASE = 12'h080;
    localparam logic [ADDR_W-1:0] ADDR_WIN_MASK = 12'hFE0;   // Eight-word window

    // Field positions
    localparam int CFG_TRIG_LSB = 0;
    localparam int CFG_IRQ_LSB  = 8;
    localparam int THR_LOW_LSB  = 0;
    localparam int THR_HIGH_LSB = 16;
    localparam int CLR_TRIG_LSB = 0;
    localparam int CLR_IRQ_LSB  = 16;
    localparam int WORD_LSB     = 2;

    // One coding serves both the fault trigger and the interrupt selection
    typedef enum logic [MODE_W-1:0] {
        fault_trig_off             = 4'h0,
        fault_trig_low_every       = 4'h1,
        fault_trig_low_entry       = 4'h2,
        fault_trig_low_every_hyst  = 4'h3,
        fault_trig_low_entry_hyst  = 4'h4,
        fault_trig_mid_every       = 4'h5,
        fault_trig_mid_entry       = 4'h6,
        fault_trig_high_every      = 4'h7,
        fault_trig_high_entry      = 4'h8,
        fault_trig_high_every_hyst = 4'h9,
        fault_trig_high_entry_hyst = 4'hA
    } adcm_mode_t;

    typedef enum logic [1:0] {
        band_none = 2'b00,
        band_low  = 2'b01,
        band_mid  = 2'b10,
        band_high = 2'b11
    } adcm_band_t;

    // Result stream word
    typedef struct packed {
        logic [RES_W-1:0]     data;
        logic [CMP_IDX_W-1:0] cmp;
        logic [SEQ_W-1:0]     seq;
    } adcm_result_t;

    typedef struct packed {
        adcm_mode_t       trig_mode;
        adcm_mode_t       irq_mode;
        logic [RES_W-1:0] low_threshold;
        logic [RES_W-1:0] high_threshold;
    } adcm_cfg_t;

    typedef struct packed {
        adcm_band_t prev;
        logic       seen;   // Opposite band visited since last assertion
    } adcm_hist_t;

    typedef struct packed {
        logic       fire;
        adcm_hist_t hist;
    } adcm_eval_t;

    localparam adcm_cfg_t  CFG_RST  = '{fault_trig_off, fault_trig_off, 12'h000, 12'h000};
    localparam adcm_hist_t HIST_RST = '{band_none, 1'b0};

endpackage

// ===== core/adcm_digital_comparator.sv
// Converter digital comparators with fault triggers, interrupt and APB registers
// Operation
// (RULE_01) Result at or below low threshold is low band.
// (RULE_02) Result above low, at or below high threshold is mid band.
// (RULE_03) Result strictly above high threshold is high band.
// (RULE_04) One config word holds trigger mode and interrupt mode per comparator.
// (RULE_05) Trigger mode off never raises the fault trigger.
// (RULE_06) Every-mode fires for each result lying in the chosen band.
// (RULE_07) Entry-mode fires once when results move into the band.
// (RULE_08) Low hysteresis modes fire only after a high result since last firing.
// (RULE_09) High hysteresis modes fire only after a low result since last firing.
// (RULE_10) Interrupt mode offers the same choices, applied to the interrupt.
// (RULE_11) Trigger and interrupt histories reset separately by own flags.
// (RULE_12) Comparator reset returns stored history to its initial value.
// (RULE_13) Comparator interrupt status is independent of the producing sequence.
// (RULE_14) Writing a mask to status clears exactly the selected bits.
// (RULE_15) Each sequence has its own comparator interrupt enable.
// (RULE_16) Busy is true while sampling, false once samples are complete.
// (RULE_17) Software sets sequencer triggers to never before checking busy.
// (RULE_18) Each routed result is classified and evaluated in its valid cycle.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps

module adcm_digital_comparator #(
    parameter int NUM_CMP = 8
) (
    input  wire logic                         core_clk_i,
    input  wire logic                         srst_i,
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [adcm_pkg::ADDR_W-1:0]  paddr_i,
    input  wire logic [adcm_pkg::DATA_W-1:0]  pwdata_i,
    output logic      [adcm_pkg::DATA_W-1:0]  prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    input  wire logic                         res_valid_i,
    input  wire adcm_pkg::adcm_result_t       res_i,
    input  wire logic                         conv_active_i,
    output logic      [NUM_CMP-1:0]           fault_trig_o,
    output logic                              irq_o,
    output logic                              busy_o
);
    import adcm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        adcm_cfg_t  [NUM_CMP-1:0] cfg;
        adcm_hist_t [NUM_CMP-1:0] trig_hist;
        adcm_hist_t [NUM_CMP-1:0] irq_hist;
        logic       [NUM_CMP-1:0] status;
        logic       [NUM_CMP-1:0] mask;
        logic       [NUM_SEQ-1:0] seq_en;
        logic       [NUM_CMP-1:0] fault;
        logic                     busy;
        logic       [DATA_W-1:0]  rdata;
        logic                     slverr;
    } adcm_state_t;

    adcm_state_t state_reg;
    adcm_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Mode evaluation

    // Hysteresis memory is only meaningful for the mode that set it; a mode
    // change mid-stream keeps the flag, so software should reset history too
    function automatic adcm_eval_t adcm_eval(
        input adcm_mode_t mode,
        input adcm_band_t band,
        input adcm_hist_t hist
    );
        adcm_eval_t r;
        adcm_band_t target;
        adcm_band_t opposite;
        logic       entry;
        logic       hyst;
        target   = band_none;
        opposite = band_none;
        entry    = 1'b0;
        hyst     = 1'b0;
        r.fire   = 1'b0;
        r.hist   = '{band, hist.seen};
        case (mode)
            fault_trig_low_every: begin
                target = band_low;                              // [RULE_06]
            end
            fault_trig_low_entry: begin
                target = band_low;
                entry  = 1'b1;                                  // [RULE_07]
            end
            fault_trig_low_every_hyst: begin
                target   = band_low;
                hyst     = 1'b1;
                opposite = band_high;                           // [RULE_08]
            end
            fault_trig_low_entry_hyst: begin
                target   = band_low;
                entry    = 1'b1;
                hyst     = 1'b1;
                opposite = band_high;                           // [RULE_08]
            end
            fault_trig_mid_every: begin
                target = band_mid;                              // [RULE_06]
            end
            fault_trig_mid_entry: begin
                target = band_mid;
                entry  = 1'b1;                                  // [RULE_07]
            end
            fault_trig_high_every: begin
                target = band_high;                             // [RULE_06]
            end
            fault_trig_high_entry: begin
                target = band_high;
                entry  = 1'b1;                                  // [RULE_07]
            end
            fault_trig_high_every_hyst: begin
                target   = band_high;
                hyst     = 1'b1;
                opposite = band_low;                            // [RULE_09]
            end
            fault_trig_high_entry_hyst: begin
                target   = band_high;
                entry    = 1'b1;
                hyst     = 1'b1;
                opposite = band_low;                            // [RULE_09]
            end
            default: begin
                target = band_none;                             // [RULE_05]
            end
        endcase
        r.fire = (target != band_none) && (band == target)
               && (!entry || hist.prev != target)
               && (!hyst || hist.seen);
        // Firing consumes the hysteresis arm; visiting the far band rearms it
        if (hyst) begin
            if (r.fire) begin
                r.hist.seen = 1'b0;                             // [RULE_08] [RULE_09]
            end else if (band == opposite) begin
                r.hist.seen = 1'b1;
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Per-comparator classification

    logic       [NUM_CMP-1:0] hit;
    adcm_eval_t [NUM_CMP-1:0] trig_ev;
    adcm_eval_t [NUM_CMP-1:0] irq_ev;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi = gi + 1) begin : g_cmp
            adcm_band_t band;
            // Result is routed to this unit in its valid cycle
            assign hit[gi] = res_valid_i && (res_i.cmp == CMP_IDX_W'(gi));  // [RULE_18]
            // Three bands from two thresholds
            always_comb begin
                if (res_i.data <= state_reg.cfg[gi].low_threshold) begin
                    band = band_low;                            // [RULE_01]
                end else if (res_i.data <= state_reg.cfg[gi].high_threshold) begin
                    band = band_mid;                            // [RULE_02]
                end else begin
                    band = band_high;                           // [RULE_03]
                end
            end
            assign trig_ev[gi] = adcm_eval(state_reg.cfg[gi].trig_mode, band,
                                           state_reg.trig_hist[gi]);
            assign irq_ev[gi]  = adcm_eval(state_reg.cfg[gi].irq_mode, band,
                                           state_reg.irq_hist[gi]);  // [RULE_10]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    logic                 setup;
    logic                 wr_acc;
    logic                 in_cfg;
    logic                 in_thr;
    logic                 mapped;
    logic [CMP_IDX_W-1:0] widx;

    assign setup  = psel_i && !penable_i;
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign widx   = paddr_i[WORD_LSB +: CMP_IDX_W];

    // Window hits need the index in range so absent units stay unmapped
    always_comb begin
        in_cfg = 1'b0;
        in_thr = 1'b0;
        mapped = 1'b0;
        if (paddr_i[WORD_LSB-1:0] != '0) begin
            mapped = 1'b0;
        end else if (paddr_i == ADDR_BUSY || paddr_i == ADDR_STATUS) begin
            mapped = 1'b1;
        end else if (paddr_i == ADDR_SEQ_EN || paddr_i == ADDR_MASK) begin
            mapped = 1'b1;
        end else if (paddr_i == ADDR_CLR_HIST) begin
            mapped = 1'b1;
        end else if ((paddr_i & ADDR_WIN_MASK) == ADDR_CFG_BASE) begin
            in_cfg = (int'(widx) < NUM_CMP);
            mapped = in_cfg;
        end else if ((paddr_i & ADDR_WIN_MASK) == ADDR_THR_BASE) begin
            in_thr = (int'(widx) < NUM_CMP);
            mapped = in_thr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_next       = state_reg;
        state_next.fault = '0;
        state_next.busy  = conv_active_i;                       // [RULE_16]

        // Read data captured in the setup cycle so prdata comes from a flop
        if (setup) begin
            state_next.rdata  = '0;
            state_next.slverr = !mapped;
            if (paddr_i == ADDR_BUSY) begin
                state_next.rdata = DATA_W'(state_reg.busy);     // [RULE_16]
            end else if (paddr_i == ADDR_STATUS) begin
                state_next.rdata = DATA_W'(state_reg.status);   // [RULE_13]
            end else if (paddr_i == ADDR_SEQ_EN) begin
                state_next.rdata = DATA_W'(state_reg.seq_en);
            end else if (paddr_i == ADDR_MASK) begin
                state_next.rdata = DATA_W'(state_reg.mask);
            end else if (in_cfg) begin
                state_next.rdata[CFG_TRIG_LSB +: MODE_W] = state_reg.cfg[widx].trig_mode;
                state_next.rdata[CFG_IRQ_LSB +: MODE_W]  = state_reg.cfg[widx].irq_mode;
            end else if (in_thr) begin
                state_next.rdata[THR_LOW_LSB +: RES_W]  = state_reg.cfg[widx].low_threshold;
                state_next.rdata[THR_HIGH_LSB +: RES_W] = state_reg.cfg[widx].high_threshold;
            end
        end

        // Register writes take effect at the access edge
        if (wr_acc) begin
            if (paddr_i == ADDR_SEQ_EN) begin
                state_next.seq_en = pwdata_i[NUM_SEQ-1:0];      // [RULE_15]
            end else if (paddr_i == ADDR_MASK) begin
                state_next.mask = pwdata_i[NUM_CMP-1:0];
            end else if (in_cfg) begin
                state_next.cfg[widx].trig_mode =
                    adcm_mode_t'(pwdata_i[CFG_TRIG_LSB +: MODE_W]);  // [RULE_04]
                state_next.cfg[widx].irq_mode  =
                    adcm_mode_t'(pwdata_i[CFG_IRQ_LSB +: MODE_W]);   // [RULE_04]
            end else if (in_thr) begin
                state_next.cfg[widx].low_threshold  = pwdata_i[THR_LOW_LSB +: RES_W];
                state_next.cfg[widx].high_threshold = pwdata_i[THR_HIGH_LSB +: RES_W];
            end
        end

        // Write-one-to-clear; a same-cycle event keeps its bit
        if (wr_acc && paddr_i == ADDR_STATUS) begin
            state_next.status = state_reg.status & ~pwdata_i[NUM_CMP-1:0];  // [RULE_14]
        end

        for (int k = 0; k < NUM_CMP; k++) begin
            if (hit[k]) begin
                state_next.trig_hist[k] = trig_ev[k].hist;      // [RULE_18]
                state_next.irq_hist[k]  = irq_ev[k].hist;
                state_next.fault[k]     = trig_ev[k].fire;      // [RULE_05] [RULE_06]
                // Status bit is per comparator; sequence only gates it
                if (irq_ev[k].fire && state_reg.seq_en[res_i.seq]) begin
                    state_next.status[k] = 1'b1;                // [RULE_13] [RULE_15]
                end
            end
            // History reset wins over a result in the same cycle: fresh start
            if (wr_acc && paddr_i == ADDR_CLR_HIST) begin
                if (pwdata_i[CLR_TRIG_LSB + k]) begin
                    state_next.trig_hist[k] = HIST_RST;         // [RULE_11] [RULE_12]
                end
                if (pwdata_i[CLR_IRQ_LSB + k]) begin
                    state_next.irq_hist[k] = HIST_RST;          // [RULE_11] [RULE_12]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_reg           <= '0;
            state_reg.cfg       <= {NUM_CMP{CFG_RST}};
            state_reg.trig_hist <= {NUM_CMP{HIST_RST}};
            state_reg.irq_hist  <= {NUM_CMP{HIST_RST}};
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Zero wait states: the read word was taken at setup
    assign pready_o     = psel_i && penable_i;
    assign prdata_o     = state_reg.rdata;
    assign pslverr_o    = psel_i && penable_i && state_reg.slverr;
    assign fault_trig_o = state_reg.fault;
    assign irq_o        = |(state_reg.status & state_reg.mask);
    assign busy_o       = state_reg.busy;

endmodule

// ===== tb/adcm_dc_asserts.sv
// Port-level assertions for the converter digital comparator block
`timescale 1ns/1ps

module adcm_dc_asserts #(
    parameter int NUM_CMP = 8
) (
    input wire logic                        core_clk_i,
    input wire logic                        srst_i,
    input wire logic                        psel_i,
    input wire logic                        penable_i,
    input wire logic                        pwrite_i,
    input wire logic [adcm_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [adcm_pkg::DATA_W-1:0] pwdata_i,
    input wire logic [adcm_pkg::DATA_W-1:0] prdata_o,
    input wire logic                        pready_o,
    input wire logic                        pslverr_o,
    input wire logic                        res_valid_i,
    input wire adcm_pkg::adcm_result_t      res_i,
    input wire logic                        conv_active_i,
    input wire logic [NUM_CMP-1:0]          fault_trig_o,
    input wire logic                        irq_o,
    input wire logic                        busy_o
);
    import adcm_pkg::*;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    ////////////////////////////////////////////////////////////////////////////////
    logic cfg_seen_reg;
    logic cfg_seen_next;

    // Until a config word is written every mode is off, so nothing may fire
    always_comb begin
        cfg_seen_next = cfg_seen_reg | (psel_i & penable_i & pwrite_i & (paddr_i[11:6] == 6'h01));
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cfg_seen_reg <= 1'b0;
        end else begin
            cfg_seen_reg <= cfg_seen_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    ready_zws_a: assert property (psel_i && penable_i |-> pready_o)
        else $error("pready low in an access cycle");
    misalign_err_a: assert property (psel_i && penable_i && paddr_i[1:0] != 2'b00
        |-> pslverr_o)
        else $error("unaligned access not refused");
    busy_rise_a: assert property (conv_active_i |=> busy_o)
        else $error("busy missing while sampling");
    busy_fall_a: assert property (!conv_active_i |=> !busy_o)
        else $error("busy left high after sampling");
    fault_cause_a: assert property (fault_trig_o != '0 |-> $past(res_valid_i)
        && fault_trig_o == (NUM_CMP'(1) << $past(res_i.cmp)))
        else $error("fault pulse without matching result");
    trig_off_a: assert property (!cfg_seen_reg |-> fault_trig_o == '0)
        else $error("fault pulse with trigger mode off");
    irq_off_a: assert property (!cfg_seen_reg |-> !irq_o)
        else $error("interrupt with interrupt mode off");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(psel_i && penable_i && pwrite_i))
        else $error("interrupt dropped without a write");
    irq_rise_a: assert property ($rose(irq_o) |-> $past(res_valid_i)
        || $past(psel_i && penable_i && pwrite_i))
        else $error("interrupt raised without cause");
endmodule

bind adcm_digital_comparator adcm_dc_asserts #(.NUM_CMP(NUM_CMP)) u_dc_chk (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .res_valid_i(res_valid_i), .res_i(res_i),
    .conv_active_i(conv_active_i), .fault_trig_o(fault_trig_o), .irq_o(irq_o),
    .busy_o(busy_o)
);

// ===== tb/adcm_res_src.sv
// Converter side model: result strobes and sampler activity level
`timescale 1ns/1ps

module adcm_res_src (
    input  wire logic              core_clk_i,
    output logic                   res_valid_o,
    output adcm_pkg::adcm_result_t res_o,
    output logic                   conv_active_o
);
    import adcm_pkg::*;

    initial begin
        res_valid_o = 1'b0;
        res_o = '0;
        conv_active_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One strobe per result; the word is inverted after it so stale data never matches
    task automatic send(input adcm_result_t r);
        @(posedge core_clk_i);
        res_valid_o <= 1'b1;
        res_o <= r;
        @(posedge core_clk_i);
        res_valid_o <= 1'b0;
        res_o <= ~r;
    endtask

    // Sampler activity level, changed just after an edge
    task automatic set_run(input logic v);
        @(posedge core_clk_i);
        conv_active_o <= v;
    endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench: registers, band sorting, all modes, interrupt and busy
`timescale 1ns/1ps

module tb;
    import adcm_pkg::*;
    localparam logic [11:0] SEQV [10] = '{12'h101, 12'h100, 12'h000, 12'h201, 12'hFFF,
                                          12'h200, 12'h100, 12'h101, 12'h201, 12'h100};
    logic         core_clk = 1'b0;
    logic         srst     = 1'b1;
    logic         psel     = 1'b0;
    logic         penable  = 1'b0;
    logic         pwrite   = 1'b0;
    logic [11:0]  paddr    = '0;
    logic [31:0]  pwdata   = '0;
    logic [31:0]  prdata, rdat;
    logic         pready, pslverr, rerr, res_valid, conv_active, irq, busy, seen_f, f;
    adcm_result_t res;
    logic [3:0]   fault;
    adcm_band_t   b, prev;
    adcm_mode_t   mode;
    int           err_total = 0;
    int           total_checks = 0;

    // Four comparators only, so that a result for index 5 is routed to no unit
    adcm_digital_comparator #(.NUM_CMP(4)) dut (
        .core_clk_i(core_clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .res_valid_i(res_valid), .res_i(res),
        .conv_active_i(conv_active), .fault_trig_o(fault), .irq_o(irq), .busy_o(busy));
    adcm_res_src src (.core_clk_i(core_clk), .res_valid_o(res_valid), .res_o(res),
                      .conv_active_o(conv_active));

    always #20 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
        end
    endtask

    // APB transfer; the wait on pready is bounded so a dead slave ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_total++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(rdat, e);
    endtask

    // Sends one result and checks the fault pulse in the cycle after the strobe
    task automatic res_chk(input adcm_result_t r, input logic [31:0] e);
        src.send(r);
        #1 chk(32'(fault), e);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    function automatic adcm_band_t band_f(input logic [11:0] d);
        if (d <= 12'h100) return band_low;
        if (d <= 12'h200) return band_mid;
        return band_high;
    endfunction

    // Expected firing for one mode; s tracks a far-band visit since the last firing
    function automatic logic fire_f(input adcm_mode_t m, input adcm_band_t bb,
                                    input adcm_band_t p, inout logic s);
        adcm_band_t t;
        logic       ent, hy, r;
        t = (m inside {[1:4]}) ? band_low : (m inside {5, 6}) ? band_mid : band_high;
        ent = m inside {2, 4, 6, 8, 10};
        hy = m inside {3, 4, 9, 10};
        if (hy && bb != t && bb != band_mid) s = 1'b1;
        r = (m != fault_trig_off) && bb == t && (!ent || p != t) && (!hy || s);
        if (r && hy) s = 1'b0;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        rd(ADDR_BUSY, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_0000);
        rd(ADDR_SEQ_EN, 32'h0000_0000);
        apb(1'b0, 12'h020, '0);
        chk({rdat[30:0], rerr}, 32'h0000_0001);
        apb(1'b1, 12'h006, 32'h0000_FFFF);
        chk(32'(rerr), 32'h0000_0001);
        wr(ADDR_THR_BASE, 32'h0200_0100);
        wr(ADDR_SEQ_EN, 32'h0000_000C);
        // Every mode drives trigger and interrupt alike over one band walk
        for (int m = 0; m < 11; m++) begin
            mode = adcm_mode_t'(m[3:0]);
            wr(ADDR_CLR_HIST, 32'h0001_0001);
            wr(ADDR_CFG_BASE, {20'h0_0000, mode, 4'h0, mode});
            prev = band_none;
            seen_f = 1'b0;
            for (int i = 0; i < 10; i++) begin
                b = band_f(SEQV[i]);
                f = fire_f(mode, b, prev, seen_f);
                prev = b;
                res_chk('{SEQV[i], 3'h0, 2'h2}, 32'(f));
                rd(ADDR_STATUS, 32'(f));
                if (f) wr(ADDR_STATUS, 32'h0000_0001);
            end
        end
        #1 chk(32'(irq), 32'h0000_0000);
        // Separate history clears, then a sequence whose enable is off
        wr(ADDR_CFG_BASE, 32'h0000_0202);
        wr(ADDR_CLR_HIST, 32'h0001_0001);
        res_chk('{12'h000, 3'h0, 2'h3}, 32'h0000_0001);
        rd(ADDR_STATUS, 32'h0000_0001);
        wr(ADDR_STATUS, 32'h0000_0001);
        wr(ADDR_CLR_HIST, 32'h0000_0001);
        res_chk('{12'h000, 3'h0, 2'h2}, 32'h0000_0001);
        rd(ADDR_STATUS, 32'h0000_0000);
        wr(ADDR_CLR_HIST, 32'h0001_0001);
        res_chk('{12'h000, 3'h0, 2'h1}, 32'h0000_0001);
        rd(ADDR_STATUS, 32'h0000_0000);
        // Interrupt: raise, mask, clear with a wrong bit and then the right one
        wr(ADDR_CLR_HIST, 32'h0001_0001);
        res_chk('{12'h000, 3'h0, 2'h2}, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        wr(ADDR_MASK, 32'h0000_0001);
        #1 chk(32'(irq), 32'h0000_0001);
        rd(ADDR_MASK, 32'h0000_0001);
        wr(ADDR_STATUS, 32'h0000_0002);
        rd(ADDR_STATUS, 32'h0000_0001);
        wr(ADDR_STATUS, 32'h0000_0001);
        #1 chk(32'(irq), 32'h0000_0000);
        rd(ADDR_CLR_HIST, 32'h0000_0000);
        // Per-comparator bit position, and an index the block does not have
        wr(ADDR_CFG_BASE + 12'h00C, 32'h0000_0007);
        res_chk('{12'h001, 3'h3, 2'h0}, 32'h0000_0008);
        res_chk('{12'h001, 3'h5, 2'h0}, 32'h0000_0000);
        // Busy follows sampler activity; conversions stop before the idle check
        src.set_run(1'b1);
        rd(ADDR_BUSY, 32'h0000_0001);
        src.set_run(1'b0);
        rd(ADDR_BUSY, 32'h0000_0000);
        // Reset in mid-run returns registers to zero
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        rd(ADDR_MASK, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
